// ==== verilog/iro_pkg.sv ====
package iro_pkg;

    // Instruction word layout
    localparam int          IRO_IW         = 14;
    localparam logic [13:0] IRO_RETFI_CODE = 14'h0009;
    localparam logic [13:0] IRO_OPTLD_CODE = 14'h0062;
    localparam logic [13:0] IRO_NOP_MASK   = 14'h3FF9;
    localparam logic [13:0] IRO_NOP_CODE   = 14'h0000;

    // Interrupt control register field
    localparam int          IRO_IRQ_EN_BIT = 7;

    // Reset values
    localparam logic [7:0]  IRO_IRQCTL_RST = 8'h00;
    localparam logic [7:0]  IRO_OPTION_RST = 8'hFF;
    localparam logic [1:0]  IRO_PHASE_RST  = 2'h0;
    localparam logic [12:0] IRO_PC_RST     = 13'h0000;

    // Phase numbering within one instruction cycle
    localparam logic [1:0]  IRO_Q1 = 2'h0;
    localparam logic [1:0]  IRO_Q2 = 2'h1;
    localparam logic [1:0]  IRO_Q3 = 2'h2;
    localparam logic [1:0]  IRO_Q4 = 2'h3;

    typedef enum logic [1:0] {
        IRO_OP_OTHER,
        IRO_OP_NOP,
        IRO_OP_RETFI,
        IRO_OP_OPTLD
    } iro_op_t;

    typedef struct packed {
        logic        valid;
        logic [13:0] word;
    } iro_fetch_t;

    typedef struct packed {
        logic        pop;
        logic        load_pc;
        logic        flush;
    } iro_stack_t;

endpackage : iro_pkg

// ==== verilog/iro_decoder.sv ====
// Function
// (RQ1) Return pops the stack into the PC in Q4 of its first cycle.
// (RQ2) Return sets the global interrupt enable, bit 7, in Q3 of cycle 1.
// (RQ3) Return is one word, two cycles, second cycle idle, no flags touched.
// (RQ4) Word 00 0000 0000 1001 decodes as return-from-interrupt.
// (RQ5) Option-load copies W into the option register in one cycle.
// (RQ6) Word 00 0000 0110 0010 is option-load; option stays file-accessible.
// (RQ7) Software should write option by file address, not by option-load.
// (RQ8) Word 00 0000 0000 0xx0 is a one-cycle no-operation, x bits ignored.
// (RQ9) In the idle cycle after return the prefetched word is discarded.
`timescale 1ns/10ps
`default_nettype none

module iro_decoder
    import iro_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Phase and fetched instruction
    input  wire logic [1:0]  phase,
    input  wire iro_fetch_t  fetch,
    // Working register and file-register write port for the option register
    input  wire logic [7:0]  w_reg,
    input  wire logic        opt_file_we,
    input  wire logic [7:0]  opt_file_wdata,
    // Interrupt control file-register write port
    input  wire logic        irq_file_we,
    input  wire logic [7:0]  irq_file_wdata,
    // Stack and program counter
    input  wire logic [12:0] stack_top,
    output var iro_stack_t   stack_ctl,
    output logic [12:0]      pc_load_value,
    // Register contents
    output logic [7:0]       irq_control_reg,
    output logic [7:0]       option_reg,
    output logic             global_irq_enable,
    // Status
    output logic             status_we,
    output logic             idle_cycle
);

    function automatic iro_op_t iro_decode(input logic [13:0] w);
        if (w == IRO_RETFI_CODE)                              // RQ4
            return IRO_OP_RETFI;
        else if (w == IRO_OPTLD_CODE)                         // RQ6
            return IRO_OP_OPTLD;
        else if ((w & IRO_NOP_MASK) == IRO_NOP_CODE)          // RQ8
            return IRO_OP_NOP;
        else
            return IRO_OP_OTHER;
    endfunction : iro_decode

    logic second;
    logic retfi_active;

    // Decode is masked off in the idle cycle, so a prefetched word that
    // happens to be a return or option-load cannot act a second time
    wire iro_op_t    cur_op        = second ? IRO_OP_OTHER
                                            : iro_decode(fetch.word);
    wire logic       is_retfi      = fetch.valid && cur_op == IRO_OP_RETFI;
    wire logic       is_optld      = fetch.valid && cur_op == IRO_OP_OPTLD;
    wire logic       set_irq_en    = is_retfi && phase == IRO_Q3;   // RQ2
    wire logic       do_pop        = is_retfi && phase == IRO_Q4;   // RQ1
    wire logic       opt_write     = is_optld && phase == IRO_Q4;   // RQ5
    wire logic       end_cyc       = phase == IRO_Q4;

    // Software write first, then the hardware set laid over it, so a
    // same-phase write keeps its other bits but cannot drop the enable
    wire logic [7:0] irq_en_mask   = 8'h01 << IRO_IRQ_EN_BIT;
    wire logic [7:0] irq_wr_value  = irq_file_we ? irq_file_wdata
                                                 : irq_control_reg;
    wire logic [7:0] next_irq_ctrl = set_irq_en ? (irq_wr_value | irq_en_mask)
                                                : irq_wr_value;

    // Second cycle is marked from the pop edge until its own Q4
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            second <= 1'b0;
        else if (do_pop)
            second <= 1'b1;                                     // RQ3
        else if (second && end_cyc)
            second <= 1'b0;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            retfi_active <= 1'b0;
        else
            retfi_active <= is_retfi && phase != IRO_Q4;
    end

    // Hardware set wins over a concurrent software write
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            irq_control_reg <= IRO_IRQCTL_RST;
        else
            irq_control_reg <= next_irq_ctrl;                   // RQ2
    end

    // Instruction write wins over a file write in the same phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            option_reg <= IRO_OPTION_RST;
        else if (opt_write)
            option_reg <= w_reg;                                // RQ5
        else if (opt_file_we)
            option_reg <= opt_file_wdata;                       // RQ6 RQ7
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            pc_load_value <= IRO_PC_RST;
        else if (do_pop)
            pc_load_value <= stack_top;                         // RQ1
    end

    assign global_irq_enable = irq_control_reg[IRO_IRQ_EN_BIT];
    assign stack_ctl.pop     = do_pop;                          // RQ1
    assign stack_ctl.load_pc = do_pop;
    assign stack_ctl.flush   = second;                          // RQ9
    assign idle_cycle        = second;                          // RQ3
    assign status_we         = 1'b0;                            // RQ3 RQ5

    // These checks rely on the core stepping phase once per edge; a
    // stalled or skipped phase would trip the cycle-count properties
    AST_IRQ_EN_BEFORE_POP: assert property (                     // RQ2
        @(posedge clock) disable iff (rst)
        set_irq_en |=> do_pop && global_irq_enable)
        else $error("enable not set one phase before pop");

    AST_POP_LOADS_PC: assert property (                          // RQ1
        @(posedge clock) disable iff (rst)
        do_pop |=> pc_load_value == $past(stack_top))
        else $error("pc not loaded from stack top");

    AST_IDLE_FOUR: assert property (                             // RQ3
        @(posedge clock) disable iff (rst)
        do_pop |=> second [*4] ##1 !second)
        else $error("second cycle not four phases");

    AST_NO_POP_IDLE: assert property (                           // RQ9
        @(posedge clock) disable iff (rst)
        second |-> !do_pop && !opt_write && !set_irq_en)
        else $error("activity during idle cycle");

    AST_RETFI_DECODE: assert property (                          // RQ4
        @(posedge clock) disable iff (rst)
        (fetch.valid && !second && fetch.word == 14'h0009
         && phase == IRO_Q4) |-> do_pop)
        else $error("return pattern not decoded");

    AST_OPTLD: assert property (                                 // RQ5
        @(posedge clock) disable iff (rst)
        opt_write |=> option_reg == $past(w_reg))
        else $error("option not loaded from W");

    AST_OPT_DECODE: assert property (                            // RQ6
        @(posedge clock) disable iff (rst)
        (fetch.valid && !second && fetch.word == 14'h0062
         && phase == IRO_Q4) |-> opt_write)
        else $error("option-load pattern not decoded");

    AST_NOP_QUIET: assert property (                             // RQ8
        @(posedge clock) disable iff (rst)
        (fetch.valid && (fetch.word & 14'h3FF9) == 14'h0000)
        |-> !do_pop && !opt_write && !set_irq_en)
        else $error("no-op caused activity");

    AST_NO_STATUS: assert property (                             // RQ3
        @(posedge clock) disable iff (rst)
        retfi_active |-> !status_we)
        else $error("status written");

    AST_POP_WITH_LOAD: assert property (                         // RQ1
        @(posedge clock) disable iff (rst)
        stack_ctl.pop |-> stack_ctl.load_pc && phase == IRO_Q4)
        else $error("pop outside Q4 or without pc load");

    // The PC value handed to the fetch path must not drift between pops
    AST_PC_STEADY: assert property (                             // RQ1
        @(posedge clock) disable iff (rst)
        !do_pop |=> pc_load_value == $past(pc_load_value))
        else $error("pc load value changed without a pop");

    AST_RETFI_Q3_SETS: assert property (                         // RQ2
        @(posedge clock) disable iff (rst)
        (fetch.valid && !second && fetch.word == 14'h0009
         && phase == IRO_Q3) |=> global_irq_enable)
        else $error("enable not set after Q3 of return");

    AST_IRQ_EN_STAYS: assert property (                          // RQ2
        @(posedge clock) disable iff (rst)
        global_irq_enable && !irq_file_we |=> global_irq_enable)
        else $error("enable cleared without a file write");

    AST_IDLE_ENDS: assert property (                             // RQ3
        @(posedge clock) disable iff (rst)
        $fell(idle_cycle) |-> phase == IRO_Q1)
        else $error("idle cycle did not end on a cycle boundary");

    AST_FLUSH_AFTER_POP: assert property (                       // RQ9
        @(posedge clock) disable iff (rst)
        $rose(stack_ctl.flush) |-> $past(do_pop))
        else $error("prefetch flush without a preceding pop");

    AST_OPT_STEADY: assert property (                            // RQ5
        @(posedge clock) disable iff (rst)
        !opt_write && !opt_file_we |=> option_reg == $past(option_reg))
        else $error("option changed without a write");

    AST_OPT_FILE: assert property (                              // RQ6
        @(posedge clock) disable iff (rst)
        opt_file_we && !opt_write |=> option_reg == $past(opt_file_wdata))
        else $error("option file write lost");

    AST_OPT_NO_IDLE: assert property (                           // RQ5
        @(posedge clock) disable iff (rst)
        opt_write |=> !idle_cycle)
        else $error("option-load took a second cycle");

    AST_NOP_NO_IDLE: assert property (                           // RQ8
        @(posedge clock) disable iff (rst)
        (fetch.valid && !second && (fetch.word & 14'h3FF9) == 14'h0000
         && phase == IRO_Q4) |=> !idle_cycle)
        else $error("no-op took a second cycle");

    AST_NO_STATUS_OPT: assert property (                         // RQ5
        @(posedge clock) disable iff (rst)
        opt_write |-> !status_we)
        else $error("status written by option-load");

endmodule : iro_decoder

`default_nettype wire

// ==== tb/test_irq_return_and_config_load_ops.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_irq_return_and_config_load_ops;
    import iro_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  phase = IRO_Q1;
    iro_fetch_t  fetch = '0;
    logic [7:0]  w_reg = 8'h3C;
    logic        opt_we = 1'b0;
    logic [7:0]  opt_wd = 8'h00;
    logic        irq_we = 1'b0;
    logic [7:0]  irq_wd = 8'h00;
    logic [12:0] stk = 13'h1A5C;
    iro_stack_t  sc;
    logic [12:0] pcv;
    logic [7:0]  irq_reg, opt_reg;
    logic        irq_en, st_we, idle;
    int          failures = 0;
    int          checks_done = 0;
    int          ticks = 0;
    iro_decoder u_dut (.clock(clock), .rst(rst), .phase(phase),
        .fetch(fetch), .w_reg(w_reg), .opt_file_we(opt_we),
        .opt_file_wdata(opt_wd), .irq_file_we(irq_we),
        .irq_file_wdata(irq_wd), .stack_top(stk), .stack_ctl(sc),
        .pc_load_value(pcv), .irq_control_reg(irq_reg),
        .option_reg(opt_reg), .global_irq_enable(irq_en),
        .status_we(st_we), .idle_cycle(idle));
    always #25 clock = ~clock;
    // Phase is ours to drive, so it free-runs Q1..Q4 from reset
    always @(posedge clock or posedge rst) begin
        if (rst) phase <= IRO_Q1;
        else phase <= phase + 2'h1;
    end
    always @(posedge clock) begin
        ticks++;
        if (ticks == 1000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [12:0] e,
                       input logic [12:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Present a word so that it starts at the next Q1
    task automatic issue(input logic [13:0] word);
        do @(negedge clock); while (phase !== IRO_Q4);
        @(posedge clock);
        fetch <= {1'b1, word};
    endtask : issue
    task automatic test_nop;
        for (int i = 0; i < 4; i++) begin
            issue({11'h000, i[1:0], 1'b0});
            repeat (4) begin
                @(negedge clock);
                chk("pop", 13'h0, 13'(sc.pop));
                chk("idle", 13'h0, 13'(idle));
            end
        end
        chk("option", 13'h0FF, 13'(opt_reg));
    endtask : test_nop
    task automatic test_ret;
        issue(IRO_RETFI_CODE);
        repeat (3) begin
            @(negedge clock);
            chk("irq_en", 13'h0, 13'(irq_en));
            chk("pop", 13'h0, 13'(sc.pop));
        end
        @(negedge clock);
        chk("irq_en", 13'h1, 13'(irq_en));
        chk("irqctl", 13'h080, 13'(irq_reg));
        chk("pop", 13'h1, 13'(sc.pop));
        chk("load", 13'h1, 13'(sc.load_pc));
        // The prefetched word here must be thrown away
        @(posedge clock);
        fetch <= {1'b1, IRO_OPTLD_CODE};
        repeat (4) begin
            @(negedge clock);
            chk("flush", 13'h1, 13'(sc.flush));
            chk("idle", 13'h1, 13'(idle));
            chk("pc", 13'h1A5C, pcv);
            chk("status", 13'h0, 13'(st_we));
        end
        @(posedge clock);
        fetch <= '0;
        @(negedge clock);
        chk("idle", 13'h0, 13'(idle));
        chk("option", 13'h0FF, 13'(opt_reg));
    endtask : test_ret
    task automatic test_optld;
        issue(IRO_OPTLD_CODE);
        repeat (4) @(negedge clock);
        chk("idle", 13'h0, 13'(idle));
        @(posedge clock);
        fetch <= '0;
        opt_we <= 1'b1;
        opt_wd <= 8'hA7;
        irq_we <= 1'b1;
        @(negedge clock);
        chk("option", 13'h03C, 13'(opt_reg));
        chk("status", 13'h0, 13'(st_we));
        @(posedge clock);
        opt_we <= 1'b0;
        irq_we <= 1'b0;
        @(negedge clock);
        chk("option", 13'h0A7, 13'(opt_reg));
        chk("irq_en", 13'h0, 13'(irq_en));
    endtask : test_optld
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk("option", 13'h0FF, 13'(opt_reg));
        chk("irqctl", 13'h000, 13'(irq_reg));
        test_nop();
        test_ret();
        test_optld();
        stop_test();
    end
endmodule : test_irq_return_and_config_load_ops
`default_nettype wire
